/* File: src/flash_ctrl_map.svh */
// register offsets, reset values, field positions and timing counts of the flash command controller
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
// register offsets in the extended register space
`define OFS_ADDR_TOP 16'hA012
`define OFS_GUARD_LOW 16'hA013
`define OFS_GUARD_HIGH 16'hA014
`define OFS_COMMAND 16'hA020
`define OFS_DATA 16'hA021
`define OFS_ADDR_HIGH 16'hA022
`define OFS_ADDR_LOW 16'hA023
`define OFS_SCALE 16'hA024
`define OFS_LOW_BOUND 16'hA025
`define OFS_HIGH_BOUND 16'hA026
// reset values
`define RST_BYTE 8'h00
`define RST_SCALE 8'h25
`define RST_LOW_BOUND 8'hFF
`define RST_HIGH_BOUND 8'h00
`define RST_TSEL 3'h4
// command register fields, and the arm bit of the high guard register
`define CMD_VERIFY_BIT 7
`define CMD_FAIL_BIT 5
`define CMD_TSEL_MSB 7
`define CMD_TSEL_LSB 5
`define CMD_CODE_MSB 4
`define ARM_BIT 7
// one-hot command codes
`define CODE_MAIN_READ 5'h10
`define CODE_MAIN_ERASE 5'h08
`define CODE_MAIN_WRITE 5'h04
`define CODE_INFO_READ 5'h02
`define CODE_INFO_WRITE 5'h01
// array geometry: main array ends below 0x8000, sector is four 256-byte units
`define MAIN_END_HIGH 8'h80
`define INFO_USER_FIRST 8'h40
`define RP_PAGE_MAX 4'hF
// write durations in program-timebase cycles, per time-out select code
`define TW0 14'd55
`define TW1 14'd60
`define TW2 14'd65
`define TW3 14'd69
`define TW4 14'd75
`define TW5 14'd80
`define TW6 14'd85
`define TW7 14'd89
// erase durations in program-timebase cycles
`define TE0 14'd5435
`define TE1 14'd5953
`define TE2 14'd6452
`define TE3 14'd6897
`define TE4 14'd7408
`define TE5 14'd7906
`define TE6 14'd8404
`define TE7 14'd8889
`endif

/* File: src/flash_ctrl_pkg.sv */
// types shared by the flash command controller
package flash_ctrl_pkg;
  typedef enum logic [2:0] {st_idle, st_check, st_read_cap, st_hold, st_verify_rd, st_verify_cap} state_e;

  // one access from the cpu to the extended register space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  // request to the flash macro
  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic info_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } flash_req_s;

  // whole state of the controller
  typedef struct packed {
    state_e state;
    logic [7:0] phase;
    logic [13:0] ticks;
    logic [7:0] addr_top;
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic [7:0] data;
    logic [4:0] code;
    logic [2:0] tsel;
    logic fail;
    logic verify_ok;
    logic [7:0] scale;
    logic [7:0] low_bound;
    logic [7:0] high_bound;
    logic [7:0] rp_low;
    logic [6:0] rp_high;
    logic arm;
    logic [7:0] rdata;
    logic stall;
    flash_req_s freq;
    logic [7:0] code_data;
    logic wm_s1;
    logic wm_s2;
  } ctrl_s;
endpackage

/* File: src/flash_command_controller.sv */
// flash command sequencer between the cpu register space and the embedded flash array
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"

module flash_command_controller (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // cpu extended register space
  input flash_ctrl_pkg::bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  output logic cpu_stall,
  // code fetch path
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_raw_data,
  output logic [7:0] fetch_data,
  // flash macro
  output flash_ctrl_pkg::flash_req_s flash_req,
  input wire logic [7:0] flash_rdata,
  // external programmer mode pin
  input wire logic writer_mode
);
  import flash_ctrl_pkg::*;

  // ==========================================================
  // helper functions
  // ==========================================================

  // write duration for a time-out select code
  function automatic logic [13:0] write_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: write_cycles = `TW0;
      3'h1: write_cycles = `TW1;
      3'h2: write_cycles = `TW2;
      3'h3: write_cycles = `TW3;
      3'h4: write_cycles = `TW4;
      3'h5: write_cycles = `TW5;
      3'h6: write_cycles = `TW6;
      default: write_cycles = `TW7;
    endcase
  endfunction

  // erase duration for a time-out select code
  function automatic logic [13:0] erase_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: erase_cycles = `TE0;
      3'h1: erase_cycles = `TE1;
      3'h2: erase_cycles = `TE2;
      3'h3: erase_cycles = `TE3;
      3'h4: erase_cycles = `TE4;
      3'h5: erase_cycles = `TE5;
      3'h6: erase_cycles = `TE6;
      default: erase_cycles = `TE7;
    endcase
  endfunction

  // read protection: lowest set bit n guards pages n+1 .. 0xF
  function automatic logic rp_hit(input logic [15:0] a, input logic [14:0] bits);
    logic hit;
    logic found;
    hit = 1'b0;
    found = 1'b0;
    for (int n = 0; n < 15; n++) begin
      if (bits[n] && !found) begin
        found = 1'b1;
        hit = (a[15:12] >= 4'(n + 1)) && (a[15:12] <= `RP_PAGE_MAX);
      end
    end
    rp_hit = hit;
  endfunction

  // guard zones, counted in 256-byte units
  function automatic logic guarded(input logic [7:0] first, input logic [7:0] last,
                                   input logic [7:0] lo, input logic [7:0] hi);
    guarded = (first < lo)
            || ({1'b0, last} > ({1'b0, hi} + 9'h001));
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  localparam ctrl_s RESET_STATE = '{
    state: st_idle, phase: 8'h00, ticks: 14'h0000,
    addr_top: `RST_BYTE, addr_high: `RST_BYTE, addr_low: `RST_BYTE, data: `RST_BYTE,
    code: 5'h00, tsel: `RST_TSEL, fail: 1'b0, verify_ok: 1'b1,
    scale: `RST_SCALE, low_bound: `RST_LOW_BOUND, high_bound: `RST_HIGH_BOUND,
    rp_low: `RST_BYTE, rp_high: 7'h00, arm: 1'b0, rdata: `RST_BYTE, stall: 1'b0,
    freq: '0, code_data: `RST_BYTE, wm_s1: 1'b0, wm_s2: 1'b0};

  ctrl_s s_r;
  ctrl_s s_nxt;
  logic [8:0] phase_sum;
  logic tick;
  logic [14:0] rp_bits;
  logic main_ok;
  logic info_ok;
  logic cmd_fail;
  logic [13:0] limit;
  logic [7:0] sec_first;
  logic [7:0] sec_last;

  // timebase: accumulate scale+1 each clock, carry out of 256 is one timebase cycle
  assign phase_sum = {1'b0, s_r.phase} + {1'b0, s_r.scale} + 9'h001;
  assign tick = phase_sum[8];
  assign rp_bits = {s_r.rp_high, s_r.rp_low};
  // erase covers the four units of its sector, offset bits ignored
  assign sec_first = {s_r.addr_high[7:2], 2'b00};
  assign sec_last = {s_r.addr_high[7:2], 2'b11};
  assign main_ok = (s_r.addr_top == 8'h00) && (s_r.addr_high < `MAIN_END_HIGH);
  assign info_ok = (s_r.addr_top == 8'h00) && (s_r.addr_high == 8'h00);
  assign limit = (s_r.code == `CODE_MAIN_ERASE) ? erase_cycles(s_r.tsel) : write_cycles(s_r.tsel);

  // legality of the pending command
  always_comb begin
    case (s_r.code)
      `CODE_MAIN_READ: cmd_fail = !main_ok;
      `CODE_MAIN_ERASE: cmd_fail = !main_ok
        || guarded(sec_first, sec_last, s_r.low_bound, s_r.high_bound);
      `CODE_MAIN_WRITE: cmd_fail = !main_ok
        || guarded(s_r.addr_high, s_r.addr_high, s_r.low_bound, s_r.high_bound);
      `CODE_INFO_READ: cmd_fail = !info_ok;
      // manufacturer bytes below 0x40 only open in programmer mode
      `CODE_INFO_WRITE: cmd_fail = !info_ok || ((s_r.addr_low < `INFO_USER_FIRST) && !s_r.wm_s2);
      default: cmd_fail = 1'b1;
    endcase
  end

  // next-state logic for registers, sequencer and outputs
  always_comb begin
    s_nxt = s_r;
    s_nxt.wm_s1 = writer_mode;
    s_nxt.wm_s2 = s_r.wm_s1;
    s_nxt.phase = phase_sum[7:0];
    s_nxt.freq.rd = 1'b0;
    // read protection also masks code fetches
    s_nxt.code_data = rp_hit(fetch_addr, rp_bits) ? 8'h00 : fetch_raw_data;

    // register reads, one cycle latency; unmapped reads as zero
    if (bus_req.rd) begin
      if (bus_req.addr == `OFS_ADDR_TOP) begin
        s_nxt.rdata = s_r.addr_top;
      end else if (bus_req.addr == `OFS_GUARD_LOW) begin
        s_nxt.rdata = s_r.rp_low;
      end else if (bus_req.addr == `OFS_GUARD_HIGH) begin
        s_nxt.rdata = {s_r.arm, s_r.rp_high};
      end else if (bus_req.addr == `OFS_COMMAND) begin
        s_nxt.rdata = {s_r.verify_ok, 1'b0, s_r.fail, s_r.code};
      end else if (bus_req.addr == `OFS_DATA) begin
        s_nxt.rdata = s_r.data;
      end else if (bus_req.addr == `OFS_ADDR_HIGH) begin
        s_nxt.rdata = s_r.addr_high;
      end else if (bus_req.addr == `OFS_ADDR_LOW) begin
        s_nxt.rdata = s_r.addr_low;
      end else if (bus_req.addr == `OFS_SCALE) begin
        s_nxt.rdata = s_r.scale;
      end else if (bus_req.addr == `OFS_LOW_BOUND) begin
        s_nxt.rdata = s_r.low_bound;
      end else if (bus_req.addr == `OFS_HIGH_BOUND) begin
        s_nxt.rdata = s_r.high_bound;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    // register writes; the cpu is stalled while busy so writes are only taken in idle
    if (bus_req.wr && (s_r.state == st_idle)) begin
      if (bus_req.addr == `OFS_ADDR_TOP) begin
        s_nxt.addr_top = bus_req.wdata;
      end else if (bus_req.addr == `OFS_GUARD_LOW) begin
        if (s_r.arm) begin
          s_nxt.rp_low = s_r.rp_low | bus_req.wdata;
        end
      end else if (bus_req.addr == `OFS_GUARD_HIGH) begin
        if (s_r.arm) begin
          s_nxt.rp_high = s_r.rp_high | bus_req.wdata[6:0];
        end
        s_nxt.arm = s_r.arm | bus_req.wdata[`ARM_BIT];
      end else if (bus_req.addr == `OFS_COMMAND) begin
        s_nxt.tsel = bus_req.wdata[`CMD_TSEL_MSB:`CMD_TSEL_LSB];
        s_nxt.code = bus_req.wdata[`CMD_CODE_MSB:0];
        s_nxt.fail = 1'b0;
        s_nxt.verify_ok = 1'b1;
        s_nxt.stall = 1'b1;
        s_nxt.state = st_check;
      end else if (bus_req.addr == `OFS_DATA) begin
        s_nxt.data = bus_req.wdata;
      end else if (bus_req.addr == `OFS_ADDR_HIGH) begin
        s_nxt.addr_high = bus_req.wdata;
      end else if (bus_req.addr == `OFS_ADDR_LOW) begin
        s_nxt.addr_low = bus_req.wdata;
      end else if (bus_req.addr == `OFS_SCALE) begin
        s_nxt.scale = bus_req.wdata;
      end else if (bus_req.addr == `OFS_LOW_BOUND) begin
        s_nxt.low_bound = bus_req.wdata;
      end else if (bus_req.addr == `OFS_HIGH_BOUND) begin
        s_nxt.high_bound = bus_req.wdata;
      end
    end
    // once any range bit is set the arm is stuck at zero until reset
    if ({s_nxt.rp_high, s_nxt.rp_low} != 15'h0000) begin
      s_nxt.arm = 1'b0;
    end

    // command sequencer
    case (s_r.state)
      st_idle: begin
        s_nxt.ticks = 14'h0000;
      end
      st_check: begin
        s_nxt.freq.addr = {s_r.addr_high, s_r.addr_low};
        s_nxt.freq.wdata = s_r.data;
        s_nxt.freq.info_sel = s_r.code[1] | s_r.code[0];
        s_nxt.ticks = 14'h0000;
        if (cmd_fail) begin
          s_nxt.fail = 1'b1;
          s_nxt.stall = 1'b0;
          s_nxt.state = st_idle;
        end else if ((s_r.code == `CODE_MAIN_READ) || (s_r.code == `CODE_INFO_READ)) begin
          s_nxt.freq.rd = 1'b1;
          s_nxt.state = st_read_cap;
        end else begin
          s_nxt.freq.wr = (s_r.code != `CODE_MAIN_ERASE);
          s_nxt.freq.erase = (s_r.code == `CODE_MAIN_ERASE);
          s_nxt.state = st_hold;
        end
      end
      st_read_cap: begin
        // main reads inside the protected range return zero
        if ((s_r.code == `CODE_MAIN_READ) && rp_hit(s_r.freq.addr, rp_bits)) begin
          s_nxt.data = 8'h00;
        end else begin
          s_nxt.data = flash_rdata;
        end
        s_nxt.stall = 1'b0;
        s_nxt.state = st_idle;
      end
      st_hold: begin
        // hold the array busy for the selected number of timebase cycles
        if (tick) begin
          s_nxt.ticks = s_r.ticks + 14'h0001;
          if (s_r.ticks + 14'h0001 >= limit) begin
            s_nxt.freq.wr = 1'b0;
            s_nxt.freq.erase = 1'b0;
            if (s_r.freq.erase) begin
              s_nxt.stall = 1'b0;
              s_nxt.state = st_idle;
            end else begin
              s_nxt.state = st_verify_rd;
            end
          end
        end
      end
      st_verify_rd: begin
        s_nxt.freq.rd = 1'b1;
        s_nxt.state = st_verify_cap;
      end
      st_verify_cap: begin
        // read-back of the written byte, mismatch drops the verify flag
        if (flash_rdata != s_r.freq.wdata) begin
          s_nxt.verify_ok = 1'b0;
        end
        s_nxt.stall = 1'b0;
        s_nxt.state = st_idle;
      end
      default: begin
        s_nxt.state = st_idle;
      end
    endcase
  end

  // single state register, synchronous reset clears protection too
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign bus_rdata = s_r.rdata;
  assign cpu_stall = s_r.stall;
  assign fetch_data = s_r.code_data;
  assign flash_req = s_r.freq;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // command start and end
  a_stall_on_cmd: assert property ((s_r.state == st_idle) && bus_req.wr
    && (bus_req.addr == `OFS_COMMAND) |=> cpu_stall && s_r.verify_ok && !s_r.fail)
    else $error("command write did not stall and reset status");
  a_read_release: assert property ((s_r.state == st_read_cap)
    |=> !cpu_stall && (s_r.state == st_idle))
    else $error("read command did not release the cpu");
  a_fail_sticky: assert property ((s_r.state == st_idle)
    && !(bus_req.wr && (bus_req.addr == `OFS_COMMAND)) |=> $stable(s_r.fail))
    else $error("fail bit changed without a new command");
  // refused commands
  a_fail_invalid: assert property ((s_r.state == st_check) && !$onehot(s_r.code)
    |=> s_r.fail && !cpu_stall && (s_r.state == st_idle))
    else $error("invalid command did not fail");
  a_range_fail: assert property ((s_r.state == st_check) && (s_r.code == `CODE_MAIN_READ)
    && !main_ok |=> s_r.fail && !flash_req.rd)
    else $error("out of range read not refused");
  a_guard_skip: assert property ((s_r.state == st_check) && (s_r.code == `CODE_MAIN_WRITE)
    && (s_r.addr_high < s_r.low_bound) |=> s_r.fail && !flash_req.wr)
    else $error("write into low guard zone not refused");
  a_high_guard: assert property ((s_r.state == st_check) && (s_r.code == `CODE_MAIN_WRITE)
    && ({1'b0, s_r.addr_high} > ({1'b0, s_r.high_bound} + 9'h001)) |=> s_r.fail && !flash_req.wr)
    else $error("write into high guard zone not refused");
  a_erase_guard: assert property ((s_r.state == st_check) && (s_r.code == `CODE_MAIN_ERASE)
    && ({s_r.addr_high[7:2], 2'b00} < s_r.low_bound) |=> s_r.fail && !flash_req.erase)
    else $error("erase into low guard zone not refused");
  a_info_reserved: assert property ((s_r.state == st_check) && (s_r.code == `CODE_INFO_WRITE)
    && (s_r.addr_low < `INFO_USER_FIRST) && !s_r.wm_s2 |=> s_r.fail)
    else $error("manufacturer info write not refused");
  // read protection
  a_read_masked: assert property ((s_r.state == st_read_cap) && (s_r.code == `CODE_MAIN_READ)
    && rp_hit(s_r.freq.addr, rp_bits) |=> (s_r.data == 8'h00))
    else $error("protected read returned data");
  a_fetch_masked: assert property (rp_hit(fetch_addr, rp_bits)
    |=> (fetch_data == 8'h00))
    else $error("protected fetch returned data");
  a_rp_set_only: assert property ((($past(rp_bits) & ~rp_bits) == 15'h0000))
    else $error("read-protection bit cleared without reset");
  a_arm_locked: assert property ((rp_bits != 15'h0000) |-> !s_r.arm)
    else $error("arm bit set with a range programmed");
  // array timing and read-back
  a_hold_start: assert property ($rose(s_r.state == st_hold)
    |-> (s_r.ticks == 14'h0000))
    else $error("array hold started with a stale count");
  a_hold_time: assert property ((s_r.state == st_hold) && (s_r.ticks + 14'h0001 < limit)
    |=> (s_r.state == st_hold))
    else $error("array hold ended early");
  a_verify_fail: assert property ((s_r.state == st_verify_cap) && (flash_rdata != s_r.freq.wdata)
    |=> !s_r.verify_ok && !cpu_stall)
    else $error("verify mismatch not flagged");
endmodule // flash_command_controller

/* File: verification/flash_array_model.sv */
// behavioural flash array and info block on the far side of the command controller
`timescale 1ns/100ps

module flash_array_model (
  // clock
  input wire logic clock,
  // controller side
  input flash_ctrl_pkg::flash_req_s flash_req,
  output logic [7:0] flash_rdata,
  // code fetch side and fault injection
  input wire logic [15:0] fetch_addr,
  output logic [7:0] fetch_raw_data,
  input wire logic bad_write
);
  import flash_ctrl_pkg::*;
  // ==========================================
  // storage: 1024-byte sectors plus a 256-byte info sector
  logic [7:0] main_mem [0:32767];
  logic [7:0] info_mem [0:255];
  logic prog_d;
  logic erase_d;
  logic [7:0] rd_r;
  // erased flash reads all ones
  initial begin
    for (int i = 0; i < 32768; i++) main_mem[i] = 8'hFF;
    for (int i = 0; i < 256; i++) info_mem[i] = 8'hFF;
    prog_d = 1'b0;
    erase_d = 1'b0;
    rd_r = 8'h00;
  end
  assign fetch_raw_data = main_mem[fetch_addr[14:0]];
  // the controller takes read data in the cycle its read strobe stands, so the array answers at once
  assign flash_rdata = !flash_req.rd ? rd_r
    : flash_req.info_sel ? info_mem[flash_req.addr[7:0]] : main_mem[flash_req.addr[14:0]];
  // acts on the first cycle of a held level; bad_write stores the inverse into the main array so verify can trip
  always @(posedge clock) begin
    prog_d <= flash_req.wr;
    erase_d <= flash_req.erase;
    if (flash_req.wr && !prog_d) begin
      if (flash_req.info_sel) info_mem[flash_req.addr[7:0]] <= flash_req.wdata;
      else main_mem[flash_req.addr[14:0]] <= bad_write ? ~flash_req.wdata : flash_req.wdata;
    end
    // the offset inside the sector plays no part
    if (flash_req.erase && !erase_d) begin
      for (int i = 0; i < 1024; i++) main_mem[{flash_req.addr[14:10], 10'(i)}] <= 8'hFF;
    end
    // outside a read the data lines show a changing pattern so stale data is never mistaken
    rd_r <= ~rd_r;
  end
endmodule // flash_array_model

/* File: verification/tb.sv */
// self-checking bench for the flash command controller
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"

module tb;
  import flash_ctrl_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  bus_req_s bus_req = '0;
  logic [15:0] fetch_addr = 16'h0000;
  logic writer_mode = 1'b0;
  logic bad_write = 1'b0;
  logic [7:0] bus_rdata, fetch_data, fetch_raw_data, flash_rdata, v;
  logic cpu_stall;
  flash_req_s flash_req;
  int miscompares = 0;
  int comparisons = 0;
  int wr_len, er_len;

  flash_command_controller dut (.clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cpu_stall(cpu_stall), .fetch_addr(fetch_addr), .fetch_raw_data(fetch_raw_data),
    .fetch_data(fetch_data), .flash_req(flash_req), .flash_rdata(flash_rdata), .writer_mode(writer_mode));
  flash_array_model flash (.clock(clock), .flash_req(flash_req), .flash_rdata(flash_rdata),
    .fetch_addr(fetch_addr), .fetch_raw_data(fetch_raw_data), .bad_write(bad_write));

  always #5 clock = ~clock;

  // ==========================================
  // bus and compare helpers, all driven at the falling edge
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    bus_req = '0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock);
    bus_req = '0;
    d = bus_rdata;
  endtask
  // starts a command and waits, bounded, for the stall to drop; counts program and erase hold
  task automatic run_cmd(input logic [7:0] c);
    wr_len = 0;
    er_len = 0;
    wr_reg(`OFS_COMMAND, c);
    // looked at right after the command edge: a refused command drops the stall one cycle later
    chk("stall", 16'h0001, {15'h0, cpu_stall});
    for (int n = 0; n < 10000; n++) begin
      @(negedge clock);
      if (flash_req.wr === 1'b1) wr_len++;
      if (flash_req.erase === 1'b1) er_len++;
      if (cpu_stall === 1'b0) return;
    end
    chk("command end", 16'h0001, 16'h0000);
    end_of_test();
  endtask
  task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    wr_reg(`OFS_ADDR_HIGH, a[15:8]);
    wr_reg(`OFS_ADDR_LOW, a[7:0]);
    wr_reg(`OFS_DATA, d);
    run_cmd(c);
  endtask
  task automatic st(input logic [7:0] e);
    rd_reg(`OFS_COMMAND, v);
    chk("status", {8'h00, e}, {8'h00, v});
  endtask
  task automatic dat(input logic [7:0] e);
    rd_reg(`OFS_DATA, v);
    chk("data", {8'h00, e}, {8'h00, v});
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [15:0] ofs [11] = '{16'hA012, 16'hA013, 16'hA014, 16'hA020, 16'hA021, 16'hA022, 16'hA023,
      16'hA024, 16'hA025, 16'hA026, 16'hA030};
    logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h25, 8'hFF, 8'h00, 8'h00};
    for (int k = 0; k < 11; k++) begin
      rd_reg(ofs[k], v);
      chk("reset value", {8'h00, rv[k]}, {8'h00, v});
    end
    $display("reset values done");
  endtask
  task automatic t_write();
    int wt [8] = '{55, 60, 65, 69, 75, 80, 85, 89};
    wr_reg(`OFS_SCALE, 8'hFF);
    op(16'h1234, 8'hA5, 8'h04);
    st(8'hA4);
    chk("guarded hold", 16'h0000, 16'(wr_len));
    wr_reg(`OFS_LOW_BOUND, 8'h00);
    wr_reg(`OFS_HIGH_BOUND, 8'h7E);
    for (int k = 0; k < 8; k++) begin
      op(16'h1234 + 16'(k), 8'hA5 ^ 8'(k), {3'(k), 5'h04});
      chk("write hold", 16'(wt[k]), 16'(wr_len));
      st(8'h84);
    end
    op(16'h2345, 8'h3C, 8'hE4);
    op(16'h1237, 8'h00, 8'hF0);
    dat(8'hA6);
    st(8'h90);
    $display("write done");
  endtask
  task automatic t_verify();
    bad_write = 1'b1;
    op(16'h1300, 8'h5A, 8'hE4);
    rd_reg(`OFS_COMMAND, v);
    chk("verify bit", 16'h0000, {15'h0, v[7]});
    bad_write = 1'b0;
    op(16'h1300, 8'h00, 8'hF0);
    dat(8'hA5);
    st(8'h90);
    $display("verify done");
  endtask
  task automatic t_erase();
    op(16'h0D55, 8'h77, 8'hE4);
    op(16'h0DAA, 8'h00, 8'h08);
    chk("erase hold", 16'd5435, 16'(er_len));
    op(16'h0D55, 8'h00, 8'hF0);
    dat(8'hFF);
    op(16'h0C00, 8'h00, 8'hE8);
    chk("erase hold", 16'd8889, 16'(er_len));
    st(8'h88);
    op(16'h1234, 8'h00, 8'hF0);
    dat(8'hA5);
    $display("erase done");
  endtask
  task automatic t_fail();
    logic [4:0] bad [3] = '{5'h03, 5'h12, 5'h18};
    for (int k = 0; k < 3; k++) begin
      op(16'h1234, 8'h00, {3'h7, bad[k]});
      st({3'h5, bad[k]});
    end
    op(16'h8000, 8'h00, 8'hF0);
    st(8'hB0);
    wr_reg(`OFS_ADDR_TOP, 8'h01);
    op(16'h0100, 8'h00, 8'hF0);
    st(8'hB0);
    wr_reg(`OFS_ADDR_TOP, 8'h00);
    op(16'h0100, 8'h00, 8'hF0);
    st(8'h90);
    $display("failures done");
  endtask
  task automatic t_guard();
    logic [7:0] gl [4] = '{8'h13, 8'h12, 8'h00, 8'h00};
    logic [7:0] gh [4] = '{8'h7E, 8'h7E, 8'h10, 8'h11};
    logic [7:0] ge [4] = '{8'hA4, 8'h84, 8'hA4, 8'h84};
    for (int k = 0; k < 4; k++) begin
      wr_reg(`OFS_LOW_BOUND, gl[k]);
      wr_reg(`OFS_HIGH_BOUND, gh[k]);
      op(16'h1240 + 16'(k), 8'h11, 8'hE4);
      st(ge[k]);
    end
    wr_reg(`OFS_HIGH_BOUND, 8'h7E);
    wr_reg(`OFS_LOW_BOUND, 8'h11);
    op(16'h1240, 8'h00, 8'hE8);
    st(8'hA8);
    $display("guard zones done");
  endtask
  task automatic t_info();
    op(16'h0020, 8'h42, 8'hE1);
    st(8'hA1);
    writer_mode = 1'b1;
    repeat (3) @(negedge clock);
    op(16'h0020, 8'h42, 8'hE1);
    st(8'h81);
    writer_mode = 1'b0;
    repeat (3) @(negedge clock);
    op(16'h0040, 8'h24, 8'hE1);
    st(8'h81);
    op(16'h0040, 8'h00, 8'hE2);
    dat(8'h24);
    op(16'h0020, 8'h00, 8'hE2);
    dat(8'h42);
    $display("info block done");
  endtask
  task automatic t_protect();
    wr_reg(`OFS_GUARD_LOW, 8'h02);
    rd_reg(`OFS_GUARD_LOW, v);
    chk("range unarmed", 16'h0000, {8'h00, v});
    wr_reg(`OFS_GUARD_HIGH, 8'h80);
    rd_reg(`OFS_GUARD_HIGH, v);
    chk("arm", 16'h0080, {8'h00, v});
    wr_reg(`OFS_GUARD_LOW, 8'h02);
    wr_reg(`OFS_GUARD_LOW, 8'h05);
    rd_reg(`OFS_GUARD_LOW, v);
    chk("range", 16'h0002, {8'h00, v});
    rd_reg(`OFS_GUARD_HIGH, v);
    chk("arm stuck", 16'h0000, {8'h00, v});
    op(16'h2345, 8'h00, 8'hF0);
    dat(8'h00);
    op(16'h1234, 8'h00, 8'hF0);
    dat(8'hA5);
    fetch_addr = 16'h2345;
    repeat (2) @(negedge clock);
    chk("fetch", 16'h0000, {8'h00, fetch_data});
    fetch_addr = 16'h1234;
    repeat (2) @(negedge clock);
    chk("fetch", 16'h00A5, {8'h00, fetch_data});
    rst = 1'b1;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    rd_reg(`OFS_GUARD_LOW, v);
    chk("range after reset", 16'h0000, {8'h00, v});
    $display("read protection done");
  endtask

  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_write();
    t_verify();
    t_erase();
    t_fail();
    t_guard();
    t_info();
    t_protect();
    end_of_test();
  end
endmodule // tb
